// ===== verification/ipcfg_core_model.sv
// Core-side model that takes presented requests
//========================================
// Core model
module ipcfg_core_model (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire ipcfg_pkg::ipcfg_irq_t irq,
  output logic [20:0]                fetch_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_q;
  // Fetch only on a new request, as a core would
  always_ff @(posedge mclk) begin
    req_q <= sys_rst ? 1'h0 : irq.req;
    if (sys_rst) fetch_q <= 21'h000000;
    else if (irq.req && !req_q) fetch_q <= irq.address;
  end
endmodule : ipcfg_core_model

// ===== verification/tb_top.sv
// Self-checking bench for the interrupt priority block
`include "ipcfg_params.svh"
//========================================
// Bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  mclk = 1'h0;
  logic                  sys_rst = 1'h1;
  logic                  clk_en = 1'h1;
  ipcfg_pkg::ipcfg_bus_t bus = '0;
  logic [63:0]           irq_in = '1;
  logic                  low_power = 1'h0;
  logic [15:0]           rdata_q;
  ipcfg_pkg::ipcfg_irq_t irq_out_q;
  logic                  wake_q;
  logic [20:0]           fetch_q;
  integer                failures = 0;
  integer                checks = 0;
  integer                seed = 48;
  logic [15:0]           pri = 16'h0000;
  logic [13:0]           vb = 14'h0000;
  logic [8:0]            e;
  logic [5:0]            fm0 = 6'h00;
  logic [5:0]            fm1 = 6'h00;
  logic [20:0]           fa0 = 21'h000000;
  logic [20:0]           fa1 = 21'h000000;
  int                    src[6] = '{0, 1, 3, 4, 5, 6};
  always #25 mclk = ~mclk;
  ipcfg_top i_ipcfg_top (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus),
    .irq_in(irq_in), .low_power(low_power), .rdata_q(rdata_q), .irq_out_q(irq_out_q),
    .wake_q(wake_q));
  ipcfg_core_model i_ipcfg_core_model (.mclk(mclk), .sys_rst(sys_rst), .irq(irq_out_q),
    .fetch_q(fetch_q));
  // Highest code wins; downward scan makes the lower source win a tie
  function automatic logic [8:0] win(input logic [15:0] p, input logic [7:0] r);
    logic [8:0] w;
    w = 9'h000;
    for (int s = 7; s >= 0; s--)
      if (r[s] && p[15-2*s -: 2] != 2'h0 && p[15-2*s -: 2] >= w[7:6])
        w = {1'h1, p[15-2*s -: 2], 6'(s)};
    return w;
  endfunction : win
  // Level-2 match takes the fast pair, pair 0 ahead of pair 1
  function automatic logic [20:0] vaddr(input logic [8:0] w);
    if (w[7:6] == `IPCFG_FAST_LEVEL && w[5:0] == fm0) return fa0;
    if (w[7:6] == `IPCFG_FAST_LEVEL && w[5:0] == fm1) return fa1;
    return {vb, 1'h0, w[5:0]};
  endfunction : vaddr
  task automatic chk(input string n, input logic [20:0] x, input logic [20:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '0;
    #1;
  endtask : acc
  task automatic go(input logic [63:0] r);
    @(posedge mclk);
    irq_in <= r;
    repeat (3) @(posedge mclk);
    #1;
  endtask : go
  task automatic out_chk();
    logic fh;
    e = win(pri, irq_in[7:0]);
    fh = e[8] && e[7:6] == `IPCFG_FAST_LEVEL && (e[5:0] == fm0 || e[5:0] == fm1);
    chk("req", 21'(e[8]), 21'(irq_out_q.req));
    chk("level", 21'(e[7:6]), 21'(irq_out_q.level_code));
    chk("vector", 21'(e[5:0]), 21'(irq_out_q.vector));
    chk("fast flag", 21'(fh), 21'(irq_out_q.fast));
    if (e[8]) chk("address", vaddr(e), irq_out_q.address);
  endtask : out_chk
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'h0;
    acc(1'h0, `IPCFG_OFF_PRI0, 16'h0000);
    chk("pri0 reset", 21'h000000, 21'(rdata_q));
    go('1);
    out_chk();
    vb = 14'($random(seed));
    acc(1'h1, `IPCFG_OFF_VBASE, 16'(vb));
    foreach (src[i]) for (int c = 1; c < 4; c++) begin
      pri = 16'(c) << (14 - 2 * src[i]);
      acc(1'h1, `IPCFG_OFF_PRI0, pri);
      acc(1'h0, `IPCFG_OFF_PRI0, 16'h0000);
      chk("pri0", 21'(pri), 21'(rdata_q));
      go(64'h1 << src[i]);
      out_chk();
    end
    // All equal level: tie goes to the lowest number
    pri = 16'h5155;
    acc(1'h1, `IPCFG_OFF_PRI0, pri);
    go(64'h00000000000000F8);
    out_chk();
    for (int k = 0; k < 24; k++) begin
      pri = 16'($random(seed)) & ~`IPCFG_RSVD_MASK;
      acc(1'h1, `IPCFG_OFF_PRI0, pri);
      go({$random(seed), $random(seed)});
      out_chk();
    end
    pri = 16'h0020;
    acc(1'h1, `IPCFG_OFF_PRI0, pri);
    acc(1'h1, `IPCFG_OFF_FMATCH0, 16'h0005);
    fm0 = 6'h05;
    fa0 = 21'h15A5C3;
    acc(1'h1, `IPCFG_OFF_FVLO0, 16'hA5C3);
    acc(1'h1, `IPCFG_OFF_FVHI0, 16'h0015);
    go(64'h0);
    go(64'h20);
    chk("fast", 21'h000001, 21'(irq_out_q.fast));
    chk("fast addr", 21'h15A5C3, irq_out_q.address);
    chk("core fetch", 21'h15A5C3, fetch_q);
    out_chk();
    acc(1'h1, `IPCFG_OFF_FMATCH0, 16'h003F);
    fm0 = 6'h3F;
    fm1 = 6'h05;
    fa1 = 21'h0A1234;
    acc(1'h1, `IPCFG_OFF_FMATCH1, 16'h0005);
    acc(1'h1, `IPCFG_OFF_FVLO1, 16'h1234);
    acc(1'h1, `IPCFG_OFF_FVHI1, 16'h000A);
    go(64'h20);
    chk("fast1 addr", 21'h0A1234, irq_out_q.address);
    out_chk();
    pri = 16'h0030;
    acc(1'h1, `IPCFG_OFF_PRI0, pri);
    go(64'h20);
    chk("fast", 21'h000000, 21'(irq_out_q.fast));
    out_chk();
    pri = 16'h4000;
    acc(1'h1, `IPCFG_OFF_PRI0, pri);
    go(64'h0);
    @(posedge mclk);
    low_power <= 1'h1;
    go(64'h1);
    chk("wake", 21'h000001, 21'(wake_q));
    go(64'h0);
    // Enabled only after entering low power: must not wake
    acc(1'h1, `IPCFG_OFF_PRI0, 16'h5000);
    go(64'h2);
    chk("wake late", 21'h000000, 21'(wake_q));
    @(posedge mclk);
    low_power <= 1'h0;
    acc(1'h1, `IPCFG_OFF_PRI0, pri);
    go('1);
    acc(1'h1, `IPCFG_OFF_PEND0, 16'hFFFF);
    acc(1'h0, `IPCFG_OFF_PEND0, 16'h0000);
    chk("pending0", 21'h000001, 21'(rdata_q));
    acc(1'h0, 5'h12, 16'h0000);
    chk("unmapped", 21'h000000, 21'(rdata_q));
    // Control view of the presented request, then the global off bit
    acc(1'h0, `IPCFG_OFF_CTRL, 16'h0000);
    chk("control", 21'h00A000, 21'(rdata_q));
    acc(1'h1, `IPCFG_OFF_CTRL, 16'h0020);
    go('1);
    chk("off req", 21'h000000, 21'(irq_out_q.req));
    chk("off level", 21'h000000, 21'(irq_out_q.level_code));
    acc(1'h0, `IPCFG_OFF_CTRL, 16'h0000);
    chk("control off", 21'h000020, 21'(rdata_q));
    acc(1'h1, `IPCFG_OFF_CTRL, 16'h0000);
    go('1);
    chk("on again req", 21'h000001, 21'(irq_out_q.req));
    @(posedge mclk);
    clk_en <= 1'h0;
    acc(1'h1, `IPCFG_OFF_PRI0, 16'h0000);
    @(posedge mclk);
    clk_en <= 1'h1;
    acc(1'h0, `IPCFG_OFF_PRI0, 16'h0000);
    chk("frozen pri0", 21'h004000, 21'(rdata_q));
    wrap_up();
  end
endmodule : tb_top

// ===== verilog/ipcfg_params.svh
// Register offsets, field positions, reset values and widths for the interrupt priority block
`ifndef IPCFG_PARAMS_SVH
`define IPCFG_PARAMS_SVH
`define IPCFG_OFF_PRI0      5'h00
`define IPCFG_OFF_PRI6      5'h06
`define IPCFG_OFF_VBASE     5'h07
`define IPCFG_OFF_FMATCH0   5'h08
`define IPCFG_OFF_FVLO0     5'h09
`define IPCFG_OFF_FVHI0     5'h0A
`define IPCFG_OFF_FMATCH1   5'h0B
`define IPCFG_OFF_FVLO1     5'h0C
`define IPCFG_OFF_FVHI1     5'h0D
`define IPCFG_OFF_PEND0     5'h0E
`define IPCFG_OFF_PEND3     5'h11
`define IPCFG_OFF_CTRL      5'h16
`define IPCFG_RST_WORD      16'h0000
`define IPCFG_CLK_LOCK_HI   15
`define IPCFG_LOW_VOLT_HI   13
`define IPCFG_RSVD_MASK     16'h0C00
`define IPCFG_DBG_RX_HI     9
`define IPCFG_DBG_TX_HI     7
`define IPCFG_DBG_TRACE_HI  5
`define IPCFG_DBG_BKPT_HI   3
`define IPCFG_DBG_STEP_HI   1
`define IPCFG_CODE_OFF      2'h0
`define IPCFG_FAST_LEVEL    2'h2
`define IPCFG_CTRL_OFF_BIT  5
`define IPCFG_VBASE_MASK    16'h3FFF
`define IPCFG_FMATCH_MASK   16'h003F
`define IPCFG_FVHI_MASK     16'h001F
`endif

// ===== verilog/ipcfg_pkg.sv
// Types shared by the interrupt priority block
package ipcfg_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } ipcfg_bus_t;

  typedef struct packed {
    logic        req;
    logic [1:0]  level_code;
    logic [5:0]  vector;
    logic        fast;
    logic [20:0] address;
  } ipcfg_irq_t;

  typedef enum logic [1:0] {ARB_IDLE, ARB_PRESENT} ipcfg_arb_t;
endpackage : ipcfg_pkg

// ===== verilog/ipcfg_top.sv
// Interrupt priority configuration, arbitration and vector generation
//==============================================================
// How it works
// - Bits 15:14 clock-lock priority, 00 off
// - Bits 13:12 low-voltage priority, 00 off
// - Bits 9:8 debug receive-full priority
// - Bits 7:6 debug transmit-empty priority
// - Bits 5:4 debug trace-buffer priority
// - Bits 3:2 debug breakpoint priority
// - Same level: lowest source number wins
// - Vector is base, then a zero bit, then number
// - Level-2 fast match uses fast vector registers
// - Wake request only from pre-enabled sources
`include "ipcfg_params.svh"
module ipcfg_top #(
  parameter int NSRC = 64
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire ipcfg_pkg::ipcfg_bus_t bus,
  input  wire logic [NSRC-1:0]     irq_in,
  input  wire logic                low_power,
  output logic [15:0]              rdata_q,
  output ipcfg_pkg::ipcfg_irq_t    irq_out_q,
  output logic                     wake_q
);
  //==============================================================
  // Register file
  logic [15:0] pri_q [0:6];
  logic [15:0] vbase_q, fm0_q, fm1_q, fvlo0_q, fvhi0_q, fvlo1_q, fvhi1_q;
  logic        gdis_q;
  logic [NSRC-1:0] wake_en_q;
  logic [NSRC-1:0] pend_q;
  ipcfg_pkg::ipcfg_arb_t st_q;

  // Two-bit code of one source from the packed priority words
  // Sources past the seven priority words have no field and stay off
  function automatic logic [1:0] src_code(input int s, input logic [111:0] flat);
    int top;
    top = (s < 56) ? 111 - 2 * s : 1;
    src_code = (s < 56) ? flat[top -: 2] : `IPCFG_CODE_OFF;
  endfunction : src_code

  logic [111:0] pri_flat;
  assign pri_flat = {pri_q[0], pri_q[1], pri_q[2], pri_q[3], pri_q[4], pri_q[5], pri_q[6]};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 7; i++) pri_q[i] <= `IPCFG_RST_WORD;
    end else if (clk_en && bus.wr && bus.addr <= `IPCFG_OFF_PRI6) begin
      // Source 0 sits in the top field of word 0; fields map to source order
      pri_q[bus.addr[2:0]] <= bus.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vbase_q <= 16'h0000;
      fm0_q   <= 16'h0000;
      fm1_q   <= 16'h0000;
      fvlo0_q <= 16'h0000;
      fvhi0_q <= 16'h0000;
      fvlo1_q <= 16'h0000;
      fvhi1_q <= 16'h0000;
      gdis_q  <= 1'b0;
    end else if (clk_en && bus.wr) begin
      case (bus.addr)
        `IPCFG_OFF_VBASE:   vbase_q <= bus.wdata & `IPCFG_VBASE_MASK;
        `IPCFG_OFF_FMATCH0: fm0_q   <= bus.wdata & `IPCFG_FMATCH_MASK;
        `IPCFG_OFF_FVLO0:   fvlo0_q <= bus.wdata;
        `IPCFG_OFF_FVHI0:   fvhi0_q <= bus.wdata & `IPCFG_FVHI_MASK;
        `IPCFG_OFF_FMATCH1: fm1_q   <= bus.wdata & `IPCFG_FMATCH_MASK;
        `IPCFG_OFF_FVLO1:   fvlo1_q <= bus.wdata;
        `IPCFG_OFF_FVHI1:   fvhi1_q <= bus.wdata & `IPCFG_FVHI_MASK;
        `IPCFG_OFF_CTRL:    gdis_q  <= bus.wdata[`IPCFG_CTRL_OFF_BIT];
        default: ;
      endcase
    end
  end

  //==============================================================
  // Enabled requests and the single winner at the highest live level
  logic [NSRC-1:0] live;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_live
      assign live[g] = irq_in[g] && (src_code(g, pri_flat) != `IPCFG_CODE_OFF);
    end
  endgenerate

  logic       win_ok;
  logic [5:0] win_num;
  logic [1:0] win_code;
  always_comb begin
    win_ok   = 1'b0;
    win_num  = 6'h00;
    win_code = 2'h0;
    // Highest code first, then lowest source number within it
    for (int lv = 3; lv >= 1; lv--) begin
      if (!win_ok) begin
        for (int s = NSRC - 1; s >= 0; s--) begin
          if (live[s] && src_code(s, pri_flat) == lv[1:0]) begin
            win_ok   = 1'b1;
            win_num  = s[5:0];
            win_code = lv[1:0];
          end
        end
      end
    end
  end

  logic        fast_hit;
  logic [20:0] vec_addr;
  always_comb begin
    fast_hit = win_code == `IPCFG_FAST_LEVEL &&
               (win_num == fm0_q[5:0] || win_num == fm1_q[5:0]);
    if (fast_hit && win_num == fm0_q[5:0])
      vec_addr = {fvhi0_q[4:0], fvlo0_q};
    else if (fast_hit)
      vec_addr = {fvhi1_q[4:0], fvlo1_q};
    else
      vec_addr = {vbase_q[13:0], 1'b0, win_num};
  end

  //==============================================================
  // Outputs to the core and clock manager
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_out_q <= '0;
      st_q      <= ipcfg_pkg::ARB_IDLE;
      pend_q    <= '0;
    end else if (clk_en) begin
      pend_q <= live;
      case (st_q)
        ipcfg_pkg::ARB_IDLE,
        ipcfg_pkg::ARB_PRESENT: begin
          irq_out_q.req        <= win_ok && !gdis_q;
          irq_out_q.level_code <= win_ok && !gdis_q ? win_code : 2'h0;
          irq_out_q.vector     <= win_num;
          irq_out_q.fast       <= fast_hit && win_ok;
          irq_out_q.address    <= vec_addr;
          st_q <= (win_ok && !gdis_q) ? ipcfg_pkg::ARB_PRESENT : ipcfg_pkg::ARB_IDLE;
        end
        default: st_q <= ipcfg_pkg::ARB_IDLE;
      endcase
    end
  end

  // Snapshot of enables on entry so late enables cannot wake the part
  logic low_power_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_power_q <= 1'b0;
      wake_en_q   <= '0;
      wake_q      <= 1'b0;
    end else if (clk_en) begin
      low_power_q <= low_power;
      if (low_power && !low_power_q) begin
        for (int s = 0; s < NSRC; s++)
          wake_en_q[s] <= src_code(s, pri_flat) != `IPCFG_CODE_OFF;
      end
      wake_q <= low_power_q && |(irq_in & wake_en_q);
    end
  end

  //==============================================================
  // Read path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (clk_en && bus.rd) begin
      case (bus.addr)
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06:
          rdata_q <= bus.addr == `IPCFG_OFF_PRI0 ? pri_q[0] & ~`IPCFG_RSVD_MASK
                                                 : pri_q[bus.addr[2:0]];
        `IPCFG_OFF_VBASE:   rdata_q <= vbase_q;
        `IPCFG_OFF_FMATCH0: rdata_q <= fm0_q;
        `IPCFG_OFF_FVLO0:   rdata_q <= fvlo0_q;
        `IPCFG_OFF_FVHI0:   rdata_q <= fvhi0_q;
        `IPCFG_OFF_FMATCH1: rdata_q <= fm1_q;
        `IPCFG_OFF_FVLO1:   rdata_q <= fvlo1_q;
        `IPCFG_OFF_FVHI1:   rdata_q <= fvhi1_q;
        5'h0E, 5'h0F, 5'h10, 5'h11:
          rdata_q <= pend_q[16*(bus.addr - `IPCFG_OFF_PEND0) +: 16];
        `IPCFG_OFF_CTRL:
          rdata_q <= {irq_out_q.req, irq_out_q.level_code, 7'h00,
                      gdis_q, 5'h00};
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  //==============================================================
  // Checks
  a_disabled_excluded: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && src_code(0, pri_flat) == 2'h0 |=> !pend_q[0])
    else $error("disabled source shown pending");
  a_clock_field_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> pri_q[0][15:14] == 2'h0)
    else $error("clock-lock field not reset");
  a_low_volt_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> pri_q[0][13:12] == 2'h0)
    else $error("low-voltage field not reset");
  a_rx_field_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> pri_q[0][9:8] == 2'h0)
    else $error("rx field not reset");
  a_tx_field_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> pri_q[0][7:6] == 2'h0)
    else $error("tx field not reset");
  a_trace_field_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> pri_q[0][5:4] == 2'h0)
    else $error("trace field not reset");
  a_bkpt_field_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> pri_q[0][3:2] == 2'h0)
    else $error("breakpoint field not reset");
  a_lowest_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && !gdis_q && live[0] && src_code(0, pri_flat) == 2'h3
    |=> irq_out_q.req && irq_out_q.vector == 6'h00)
    else $error("source 0 did not win");
  a_fast_vector: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && win_ok && fast_hit && win_num == fm0_q[5:0]
    |=> irq_out_q.address == $past({fvhi0_q[4:0], fvlo0_q}))
    else $error("fast vector not used");
  a_normal_vector: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && win_ok && !fast_hit |=> irq_out_q.address[5:0] == $past(win_num))
    else $error("vector number not appended");
  a_wake_gated: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && !low_power_q |=> !wake_q)
    else $error("wake outside low power");
  c_req_seen: cover property (@(posedge mclk) irq_out_q.req);
  c_fast_seen: cover property (@(posedge mclk) irq_out_q.fast);
  c_wake_seen: cover property (@(posedge mclk) wake_q);
endmodule : ipcfg_top
